// *** ssb_pkg.sv ***
// constants for the serial status bits and bit-rate block
// assumes a 32-bit APB register bus and one system clock
package ssb_pkg;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_STATUS     = 8'h00; // status flags, tx mp bit
	localparam logic [7:0] OFS_CONTROL    = 8'h04; // serial_control_reg
	localparam logic [7:0] OFS_MODE       = 8'h08; // serial_mode_reg
	localparam logic [7:0] OFS_DIVISOR    = 8'h0C; // bit_rate_divisor_reg
	localparam logic [7:0] OFS_TX_HOLDING = 8'h10; // tx_holding_reg
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
	localparam logic [7:0] OFS_IRQ_CLEAR  = 8'h18;
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'h1C;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int BIT_TX_HOLDING_EMPTY_FLAG   = 7; // status: tx holding empty
	localparam int BIT_TRANSMIT_END_FLAG   = 2; // status: transmit end
	localparam int BIT_MP_BIT_RECEIVED   = 1; // status: mp bit received
	localparam int BIT_MP_BIT_TO_SEND   = 0; // status: mp bit to send
	localparam int BIT_TE     = 5; // control: tx enable
	localparam int BIT_RE     = 4; // control: rx enable
	localparam int BIT_SYNC   = 7; // mode: 1 = synchronous
	localparam int BIT_MP     = 2; // mode: multiprocessor format
	localparam int BIT_CKS_HI = 1; // mode: prescale select high
	localparam int BIT_CKS_LO = 0; // mode: prescale select low
	localparam int IRQ_TRANSMIT_END_FLAG   = 0; // irq: transmit ended
	localparam int IRQ_TX_HOLDING_EMPTY_FLAG   = 1; // irq: holding register emptied
	localparam int IRQ_MP_BIT_RECEIVED   = 2; // irq: mp bit captured
	localparam int IRQ_W      = 3;

	// ------------------------------------------------------------
	// reset values and frame shape
	// ------------------------------------------------------------
	localparam logic [7:0] DIVISOR_RESET = 8'hFF;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] MODE_RESET    = 8'h00;
	localparam int         FRAME_W       = 11; // start, 8 data, mp, stop
	localparam logic [3:0] BITS_PLAIN    = 4'hA;
	localparam logic [3:0] BITS_MP       = 4'hB;

	// ------------------------------------------------------------
	// rate generator: 64 prescaled-clock base periods per bit
	// ------------------------------------------------------------
	localparam logic [5:0] OS_LAST        = 6'h3F;
	localparam logic [5:0] PRESC_LAST_D1  = 6'h00;
	localparam logic [5:0] PRESC_LAST_D4  = 6'h03;
	localparam logic [5:0] PRESC_LAST_D16 = 6'h0F;
	localparam logic [5:0] PRESC_LAST_D64 = 6'h3F;

	typedef enum logic [1:0] {
		SSB_IDLE  = 2'b01,
		SSB_SHIFT = 2'b10
	} ssb_tx_state_t;

endpackage : ssb_pkg

// *** ssb_rate_if.sv ***
// link between the block core and its bit-rate generator
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface ssb_rate_if;
	logic       run;       // generator counts while high
	logic [1:0] cks;       // prescale select
	logic [7:0] divisor;   // bit_rate_divisor value
	logic       bit_tick;  // one pulse at end of each bit period

	modport gen  (input run, input cks, input divisor, output bit_tick);
	modport user (output run, output cks, output divisor, input bit_tick);
endinterface : ssb_rate_if
`default_nettype wire

// *** ssb_rate_gen.sv ***
// bit-rate generator: prescaler, divisor counter, 64x oversample
// assumes run restarts counting from zero so a frame's first bit is whole
`timescale 1ns/1ps
`default_nettype none
module ssb_rate_gen
	import ssb_pkg::*;
(
	input  wire logic  pclk,
	input  wire logic  presetn,
	input  wire logic  ce,
	ssb_rate_if.gen    rate
);
	logic [5:0] presc;
	logic [7:0] base;
	logic [5:0] os;
	logic       tick;
	logic [5:0] next_presc;
	logic [7:0] next_base;
	logic [5:0] next_os;
	logic       next_tick;
	logic [5:0] presc_last;

	assign rate.bit_tick = tick;

	// ------------------------------------------------------------
	// prescaler choice: clock, /4, /16, /64
	// ------------------------------------------------------------
	always_comb
	begin
		unique case (rate.cks)
			2'h0: presc_last = PRESC_LAST_D1;
			2'h1: presc_last = PRESC_LAST_D4;
			2'h2: presc_last = PRESC_LAST_D16;
			2'h3: presc_last = PRESC_LAST_D64;
		endcase
	end

	// bit period = 64 * 4^n * (divisor + 1) clocks
	always_comb
	begin
		next_presc = presc;
		next_base  = base;
		next_os    = os;
		next_tick  = 1'b0;
		if (!rate.run)
		begin
			next_presc = '0;
			next_base  = '0;
			next_os    = '0;
		end
		else if (presc == presc_last)
		begin
			next_presc = '0;
			if (base == rate.divisor) // see (R14)
			begin
				next_base = '0;
				if (os == OS_LAST)
				begin
					next_os   = '0;
					next_tick = 1'b1;
				end
				else
					next_os = os + 6'h01;
			end
			else
				next_base = base + 8'h01;
		end
		else
			next_presc = presc + 6'h01; // see (R15)
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			presc <= '0;
			base  <= '0;
			os    <= '0;
			tick  <= 1'b0;
		end
		else if (ce)
		begin
			presc <= next_presc;
			base  <= next_base;
			os    <= next_os;
			tick  <= next_tick;
		end
	end
endmodule : ssb_rate_gen
`default_nettype wire

// *** ssb_top.sv ***
// serial status bits, bit-rate divisor and a small transmitter, APB slave
// assumes receive logic on the same clock supplies rx_done and rx_mp_in
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// (R1) the transmit-end flag is readable and software writes never change it; the code clears it along with the holding-empty flag.
// (R2) writing 0 to the holding-empty flag after reading it 1, or writing tx data, clears it.
// (R3) clearing the tx enable bit sets the transmit-end flag.
// (R4) the flag sets when a character's last bit is sent while the holding-empty flag is 1.
// (R5) after initialisation the transmit-end flag reads 1.
// (R6) in async multiprocessor format the received mp bit is captured; it resets to 0.
// (R7) the received mp bit is read-only.
// (R8) with rx enable cleared the received mp bit keeps its value.
// (R9) in async mp format the writable tx mp bit is appended to each character; resets 0.
// (R10) the tx mp bit is ignored in sync mode, with mp off, or with tx disabled.
// (R11) an 8-bit divisor with the prescale select sets the bit rate.
// (R12) the divisor is readable and writable at any time.
// (R13) the divisor loads all ones on reset and on low-power entry.
// (R14) async bit period is 64 * 4^n * (divisor + 1) prescaled clocks; the code makes it 64 * (divisor + 1) prescaled clocks.
// (R15) select 00, 01, 10, 11 gives clock, /4, /16, /64 as generator input.
// (R16) the holding-empty flag sets on transfer to the shift register or tx enable clear.
// (R17) transmit end is judged at the end of the final stop bit.
module ssb_top
	import ssb_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic        low_power_entry,
	input  wire logic        rx_done,
	input  wire logic        rx_mp_in,
	output logic             txd,
	output logic             irq
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [7:0]         control, next_control;
	logic [7:0]         mode, next_mode;
	logic [7:0]         bit_rate_divisor, next_bit_rate_divisor;
	logic [7:0]         tx_holding_reg, next_tx_holding_reg;
	logic               tx_holding_empty_flag, next_tx_holding_empty_flag;
	logic               transmit_end_flag, next_transmit_end_flag;
	logic               mp_bit_received, next_mp_bit_received;
	logic               mp_bit_to_send, next_mp_bit_to_send;
	logic               empty_seen, next_empty_seen;
	logic [IRQ_W-1:0]   irq_status, next_irq_status;
	logic [IRQ_W-1:0]   irq_enable, next_irq_enable;
	logic               next_irq;
	logic               next_pready, next_pslverr;
	logic [31:0]        next_prdata;
	ssb_tx_state_t      tx_state, next_tx_state;
	logic [FRAME_W-1:0] tx_shift_reg, next_tx_shift_reg;
	logic [3:0]         bits_left, next_bits_left;
	logic               next_txd;

	// decoded bus and mode terms
	logic        commit, wr, rd, mapped;
	logic        tx_enable_bit, rx_enable_bit, async_mp;
	logic [31:0] rd_word;
	logic [IRQ_W-1:0] irq_events;

	ssb_rate_if rate ();

	ssb_rate_gen u_rate (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.rate    (rate.gen)
	);

	assign rate.run     = (tx_state == SSB_SHIFT);
	assign rate.cks     = {mode[BIT_CKS_HI], mode[BIT_CKS_LO]}; // see (R15)
	assign rate.divisor = bit_rate_divisor;                      // see (R11)

	assign tx_enable_bit = control[BIT_TE];
	assign rx_enable_bit = control[BIT_RE];
	assign async_mp      = !mode[BIT_SYNC] && mode[BIT_MP];

	// ------------------------------------------------------------
	// APB decode: answer one cycle after the access phase starts, act when pready is seen
	// ------------------------------------------------------------
	assign commit = psel && penable && pready;
	assign wr     = commit && pwrite && !pslverr;
	assign rd     = commit && !pwrite && !pslverr;
	assign mapped = (paddr[1:0] == 2'h0) && (paddr <= OFS_IRQ_ENABLE);

	// read mux; write-only words read as zero
	always_comb
	begin
		rd_word = '0;
		unique case (paddr)
			OFS_STATUS:
			begin
				rd_word[BIT_TX_HOLDING_EMPTY_FLAG] = tx_holding_empty_flag;
				rd_word[BIT_TRANSMIT_END_FLAG] = transmit_end_flag;
				rd_word[BIT_MP_BIT_RECEIVED] = mp_bit_received;
				rd_word[BIT_MP_BIT_TO_SEND] = mp_bit_to_send;
			end
			OFS_CONTROL:    rd_word[7:0] = control;
			OFS_MODE:       rd_word[7:0] = mode;
			OFS_DIVISOR:    rd_word[7:0] = bit_rate_divisor; // see (R12)
			OFS_IRQ_STATUS: rd_word[IRQ_W-1:0] = irq_status;
			OFS_IRQ_ENABLE: rd_word[IRQ_W-1:0] = irq_enable;
			default:        rd_word = '0;
		endcase
	end

	// bus answer registers
	always_comb
	begin
		next_pready  = 1'b0;
		next_prdata  = prdata;
		next_pslverr = 1'b0;
		if (psel && penable && !pready)
		begin
			next_pready  = 1'b1;
			next_pslverr = !mapped;
			next_prdata  = (pwrite || !mapped) ? 32'h0000_0000 : rd_word;
		end
	end

	// ------------------------------------------------------------
	// transmitter and flags
	// ------------------------------------------------------------
	// hardware sets are applied after software clears so a set wins
	always_comb
	begin
		next_control               = control;
		next_mode                  = mode;
		next_bit_rate_divisor      = bit_rate_divisor;
		next_tx_holding_reg        = tx_holding_reg;
		next_tx_holding_empty_flag = tx_holding_empty_flag;
		next_transmit_end_flag     = transmit_end_flag;
		next_mp_bit_received       = mp_bit_received;
		next_mp_bit_to_send        = mp_bit_to_send;
		next_empty_seen            = empty_seen;
		next_tx_state              = tx_state;
		next_tx_shift_reg          = tx_shift_reg;
		next_bits_left             = bits_left;
		irq_events                 = '0;

		// a status read that sees the empty flag arms its clear
		if (rd && paddr == OFS_STATUS && tx_holding_empty_flag)
			next_empty_seen = 1'b1;

		// software writes; status bit 1 is never written, bit 2 only clears along with bit 7
		if (wr)
		begin
			unique case (paddr)
				OFS_STATUS:
				begin
					next_mp_bit_to_send = pwdata[BIT_MP_BIT_TO_SEND]; // see (R1) (R7)
					if (!pwdata[BIT_TX_HOLDING_EMPTY_FLAG] && empty_seen)
					begin
						next_tx_holding_empty_flag = 1'b0; // see (R2)
						next_transmit_end_flag     = 1'b0; // see (R2)
						next_empty_seen            = 1'b0;
					end
				end
				OFS_CONTROL: next_control = pwdata[7:0];
				OFS_MODE:    next_mode    = pwdata[7:0];
				OFS_DIVISOR: next_bit_rate_divisor = pwdata[7:0]; // see (R12)
				OFS_TX_HOLDING:
				begin
					next_tx_holding_reg        = pwdata[7:0];
					next_tx_holding_empty_flag = 1'b0; // see (R2)
					next_transmit_end_flag     = 1'b0; // see (R2)
					next_empty_seen            = 1'b0;
				end
				default: ;
			endcase
		end

		// received mp bit, frozen while receive is off
		if (rx_done && rx_enable_bit && async_mp) // see (R6) (R8)
		begin
			next_mp_bit_received      = rx_mp_in;
			irq_events[IRQ_MP_BIT_RECEIVED]      = 1'b1;
		end

		// transmit sequencing
		unique case (tx_state)
			SSB_IDLE:
			begin
				if (tx_enable_bit && !tx_holding_empty_flag)
				begin
					// mp bit used only in async mp format with tx enabled
					next_tx_shift_reg = async_mp
						? {1'b1, mp_bit_to_send, tx_holding_reg, 1'b0} // see (R9) (R10)
						: {2'b11, tx_holding_reg, 1'b0};               // see (R10)
					next_bits_left             = async_mp ? BITS_MP : BITS_PLAIN;
					next_tx_holding_empty_flag = 1'b1; // see (R16)
					irq_events[IRQ_TX_HOLDING_EMPTY_FLAG]       = 1'b1;
					next_tx_state              = SSB_SHIFT;
				end
			end
			SSB_SHIFT:
			begin
				if (rate.bit_tick)
				begin
					next_tx_shift_reg = {1'b1, tx_shift_reg[FRAME_W-1:1]};
					next_bits_left    = bits_left - 4'h1;
					// final stop bit just finished: line is idle now
					if (bits_left == 4'h1) // see (R17)
					begin
						next_tx_state = SSB_IDLE;
						if (tx_holding_empty_flag)
						begin
							next_transmit_end_flag = 1'b1; // see (R4)
							irq_events[IRQ_TRANSMIT_END_FLAG]   = 1'b1;
						end
					end
				end
			end
			default: next_tx_state = SSB_IDLE;
		endcase

		// tx enable off: abort, both flags set, line idle
		if (!next_control[BIT_TE])
		begin
			if (!transmit_end_flag)
				irq_events[IRQ_TRANSMIT_END_FLAG] = 1'b1;
			next_tx_holding_empty_flag = 1'b1; // see (R16)
			next_transmit_end_flag     = 1'b1; // see (R3)
			next_tx_state              = SSB_IDLE;
			next_tx_shift_reg          = '1;
			next_bits_left             = '0;
		end
	end

	assign next_txd = (next_tx_state == SSB_SHIFT) ? next_tx_shift_reg[0] : 1'b1;

	// ------------------------------------------------------------
	// interrupt: sticky events, write-one clear, set beats clear
	// ------------------------------------------------------------
	always_comb
	begin
		next_irq_status = irq_status;
		next_irq_enable = irq_enable;
		if (wr && paddr == OFS_IRQ_CLEAR)
			next_irq_status = irq_status & ~pwdata[IRQ_W-1:0];
		if (wr && paddr == OFS_IRQ_ENABLE)
			next_irq_enable = pwdata[IRQ_W-1:0];
		next_irq_status = next_irq_status | irq_events;
		next_irq        = |(next_irq_status & next_irq_enable);
	end

	// ------------------------------------------------------------
	// registers; low-power entry reinitialises all but the bus answer like reset
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			control               <= CONTROL_RESET;
			mode                  <= MODE_RESET;
			bit_rate_divisor      <= DIVISOR_RESET;   // see (R13)
			tx_holding_reg        <= '0;
			tx_holding_empty_flag <= 1'b1;
			transmit_end_flag     <= 1'b1;            // see (R5)
			mp_bit_received       <= 1'b0;            // see (R6)
			mp_bit_to_send        <= 1'b0;            // see (R9)
			empty_seen            <= 1'b0;
			irq_status            <= '0;
			irq_enable            <= '0;
			irq                   <= 1'b0;
			tx_state              <= SSB_IDLE;
			tx_shift_reg          <= '1;
			bits_left             <= '0;
			txd                   <= 1'b1;
			pready                <= 1'b0;
			prdata                <= '0;
			pslverr               <= 1'b0;
		end
		else if (ce)
		begin
			// bus answer keeps running so a pending access completes
			pready  <= next_pready;
			prdata  <= next_prdata;
			pslverr <= next_pslverr;
			if (low_power_entry)
			begin
				control               <= CONTROL_RESET;
				mode                  <= MODE_RESET;
				bit_rate_divisor      <= DIVISOR_RESET; // see (R13)
				tx_holding_reg        <= '0;
				tx_holding_empty_flag <= 1'b1;
				transmit_end_flag     <= 1'b1;          // see (R5)
				mp_bit_received       <= 1'b0;
				mp_bit_to_send        <= 1'b0;
				empty_seen            <= 1'b0;
				irq_status            <= '0;
				irq_enable            <= '0;
				irq                   <= 1'b0;
				tx_state              <= SSB_IDLE;
				tx_shift_reg          <= '1;
				bits_left             <= '0;
				txd                   <= 1'b1;
			end
			else
			begin
				control               <= next_control;
				mode                  <= next_mode;
				bit_rate_divisor      <= next_bit_rate_divisor;
				tx_holding_reg        <= next_tx_holding_reg;
				tx_holding_empty_flag <= next_tx_holding_empty_flag;
				transmit_end_flag     <= next_transmit_end_flag;
				mp_bit_received       <= next_mp_bit_received;
				mp_bit_to_send        <= next_mp_bit_to_send;
				empty_seen            <= next_empty_seen;
				irq_status            <= next_irq_status;
				irq_enable            <= next_irq_enable;
				irq                   <= next_irq;
				tx_state              <= next_tx_state;
				tx_shift_reg          <= next_tx_shift_reg;
				bits_left             <= next_bits_left;
				txd                   <= next_txd;
			end
		end
	end
endmodule : ssb_top
`default_nettype wire

// *** ssb_chk_sva.sv ***
// checker for the bus answer and the serial start bit of ssb_top
// assumes ce drops only while the bus is idle, so every access is answered
`timescale 1ns/1ps
`default_nettype none
module ssb_chk
	import ssb_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        ce,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	input wire logic        txd
);
	// ----------------------------------------
	// bus answer and line checks
	// ----------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// access phase still waiting for its answer
	sequence access_s;
		psel && penable && !pready && ce;
	endsequence
	sequence odd_addr_s;
		access_s ##0 (paddr[1:0] != 2'b00);
	endsequence
	sequence good_addr_s;
		access_s ##0 (paddr[1:0] == 2'b00 && paddr <= OFS_IRQ_ENABLE);
	endsequence

	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready high for two cycles");
	chk_ready_after: assert property (access_s |=> pready)
		else $error("access not answered next cycle");
	chk_ready_cause: assert property (pready |-> $past(psel) && $past(penable))
		else $error("pready without an access");
	chk_err_align: assert property (odd_addr_s |=> pslverr)
		else $error("misaligned access not refused");
	chk_err_mapped: assert property (good_addr_s |=> !pslverr)
		else $error("mapped access refused");
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr outside the answer");
	chk_write_zero: assert property (pready && pwrite |-> prdata == 32'h0000_0000)
		else $error("read data on a write");
	chk_start_len: assert property ($fell(txd) |-> !txd [*4])
		else $error("start bit too short");
endmodule : ssb_chk
`default_nettype wire

// *** ssb_line_rx.sv ***
// far serial station: samples txd at mid-bit and reports each frame
// assumes divisor 0 and select 00, so one bit is BIT_CLKS clocks
`timescale 1ns/1ps
`default_nettype none
module ssb_line_rx
	import ssb_pkg::*;
#(
	parameter int BIT_CLKS = 64
)
(
	input  wire logic pclk,
	input  wire logic txd,
	input  wire logic mp_on,
	output logic [7:0] rx_byte,
	output logic       rx_mp,
	output logic       stop_ok,
	output var int     frames
);
	// ----------------------------------------
	// frame sampling
	// ----------------------------------------
	// mid-bit sampling tolerates the one longer first bit
	always
	begin
		@(negedge txd);
		repeat (BIT_CLKS / 2) @(posedge pclk);
		for (int i = 0; i < 8; i++)
		begin
			repeat (BIT_CLKS) @(posedge pclk);
			rx_byte[i] = txd;
		end
		if (mp_on)
		begin
			repeat (BIT_CLKS) @(posedge pclk);
			rx_mp = txd;
		end
		repeat (BIT_CLKS) @(posedge pclk);
		stop_ok = txd;
		frames++;
	end
	// quiet values before the first frame
	initial
	begin
		frames = 0;
		rx_mp = 1'b0;
		stop_ok = 1'b0;
	end
endmodule : ssb_line_rx
`default_nettype wire

// *** testbench.sv ***
// self-checking bench for ssb_top over APB with a line receiver
// assumes ssb_pkg, ssb_chk and ssb_line_rx are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
	$display("wrong value at %0t: got %h want %h", $time, g, e); end end
module testbench
	import ssb_pkg::*;
;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        ce = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic        low_power_entry = 1'b0;
	logic        rx_done = 1'b0;
	logic        rx_mp_in = 1'b0;
	logic        mp_on = 1'b1;
	logic        pready, pslverr, txd, irq, rx_mp, stop_ok;
	logic [31:0] prdata;
	logic [7:0]  rx_byte;
	int          frames;
	int          bad_count = 0;
	int          n_checks = 0;

	// ----------------------------------------
	// clock, design and far station
	// ----------------------------------------
	always #2 pclk = ~pclk;
	ssb_top ssb_top_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.low_power_entry(low_power_entry), .rx_done(rx_done), .rx_mp_in(rx_mp_in),
		.txd(txd), .irq(irq));
	ssb_line_rx ssb_line_rx_inst (.pclk(pclk), .txd(txd), .mp_on(mp_on),
		.rx_byte(rx_byte), .rx_mp(rx_mp), .stop_ok(stop_ok), .frames(frames));

	// ----------------------------------------
	// bus tasks
	// ----------------------------------------
	// request held until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && k < 50)
		begin
			@(posedge pclk);
			k++;
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 50)
			bad_count++;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0000_0000, q, e);
		`CHK(q, x)
	endtask : rd
	task automatic wait_frame(input int n);
		int k;
		k = 0;
		while (frames < n && k < 2000)
		begin
			@(posedge pclk);
			k++;
		end
		`CHK(frames, n)
	endtask : wait_frame
	task automatic pulse_rx(input logic mp);
		@(posedge pclk);
		rx_done <= 1'b1;
		rx_mp_in <= mp;
		@(posedge pclk);
		rx_done <= 1'b0;
	endtask : pulse_rx
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : tally_and_finish

	// ----------------------------------------
	// tests
	// ----------------------------------------
	// reset values, access kinds, two frames, rx mp bit, abort, low power
	initial
	begin
		logic [31:0] q;
		logic        e;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rd(OFS_STATUS, 32'h0000_0084);
		rd(OFS_DIVISOR, 32'h0000_00FF);
		wr(OFS_STATUS, 32'h0000_0087);
		rd(OFS_STATUS, 32'h0000_0085);
		apb(1'b0, 8'h20, 32'h0000_0000, q, e);
		`CHK(e, 1'b1)
		// misaligned write is refused and must not reach the divisor
		apb(1'b1, 8'h0E, 32'h0000_0012, q, e);
		`CHK(e, 1'b1)
		rd(OFS_DIVISOR, 32'h0000_00FF);
		wr(OFS_DIVISOR, 32'h0000_0000);
		rd(OFS_DIVISOR, 32'h0000_0000);
		wr(OFS_MODE, 32'h0000_0004);
		wr(OFS_IRQ_ENABLE, 32'h0000_0001);
		wr(OFS_CONTROL, 32'h0000_0030);
		wr(OFS_TX_HOLDING, 32'h0000_00A5);
		rd(OFS_STATUS, 32'h0000_0081);
		wait_frame(1);
		`CHK(rx_byte, 8'hA5)
		`CHK(rx_mp, 1'b1)
		repeat (40) @(posedge pclk);
		rd(OFS_STATUS, 32'h0000_0085);
		`CHK(irq, 1'b1)
		rd(OFS_IRQ_STATUS, 32'h0000_0003);
		wr(OFS_IRQ_ENABLE, 32'h0000_0000);
		repeat (2) @(posedge pclk);
		`CHK(irq, 1'b0)
		wr(OFS_IRQ_CLEAR, 32'h0000_0007);
		rd(OFS_IRQ_STATUS, 32'h0000_0000);
		// mp format off: a 0 in the mp slot would spoil the stop bit
		mp_on <= 1'b0;
		wr(OFS_MODE, 32'h0000_0000);
		wr(OFS_STATUS, 32'h0000_0080);
		wr(OFS_TX_HOLDING, 32'h0000_003C);
		wait_frame(2);
		`CHK(rx_byte, 8'h3C)
		`CHK(stop_ok, 1'b1)
		repeat (40) @(posedge pclk);
		// sync mode: the received mp bit must not be captured
		wr(OFS_MODE, 32'h0000_0084);
		pulse_rx(1'b1);
		rd(OFS_STATUS, 32'h0000_0084);
		wr(OFS_MODE, 32'h0000_0004);
		pulse_rx(1'b1);
		rd(OFS_STATUS, 32'h0000_0086);
		wr(OFS_CONTROL, 32'h0000_0020);
		pulse_rx(1'b0);
		rd(OFS_STATUS, 32'h0000_0086);
		wr(OFS_STATUS, 32'h0000_0000);
		rd(OFS_STATUS, 32'h0000_0082);
		wr(OFS_CONTROL, 32'h0000_0000);
		rd(OFS_STATUS, 32'h0000_0086);
		`CHK(txd, 1'b1)
		// ce low freezes all state, low-power entry included
		ce <= 1'b0;
		low_power_entry <= 1'b1;
		@(posedge pclk);
		low_power_entry <= 1'b0;
		@(posedge pclk);
		ce <= 1'b1;
		rd(OFS_DIVISOR, 32'h0000_0000);
		@(posedge pclk);
		low_power_entry <= 1'b1;
		@(posedge pclk);
		low_power_entry <= 1'b0;
		rd(OFS_DIVISOR, 32'h0000_00FF);
		rd(OFS_MODE, 32'h0000_0000);
		tally_and_finish();
	end
	// watchdog well beyond the two frames and bus traffic
	initial
	begin
		repeat (20000) @(posedge pclk);
		bad_count++;
		tally_and_finish();
	end
endmodule : testbench
bind ssb_top ssb_chk ssb_chk_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata),
	.pslverr(pslverr), .txd(txd));
`default_nettype wire
